//--- src/prs_sequencer.sv
/*
 * Power and reset sequencer: supervises power-on sense and supply-ok
 * warning, requests mirror park and controller reset, and drives the
 * active-low external reset pin with a software release.
 * Assumes an external monitor drives both inputs; software controls
 * arrive as synchronous levels and pulses on CTRL.
 */
`timescale 1ns/1ns
// Behaviour
// [RULE1] Sense low drives reset pin low immediately
// [RULE2] After sense high, hold until software release
// [RULE3] Fault or internal reset asserts pin ~5us
// [RULE4] Pin low at least 2ms after release
// [RULE5] Software control forces pin independently
// [RULE6] Supply-ok high permits leaving reset
// [RULE7] Monitor warns 0.5ms, keeps sense high
// [RULE8] Supply-ok low 4us: park then reset
// [RULE9] Stay in reset while supply-ok low
// [RULE10] Monitor holds supply-ok high normally
// [RULE11] Supply-ok active after 625ns high
// [RULE12] Monitor holds sense low on undervoltage
// [RULE13] Synchronise inputs before duration filters
module prs_sequencer #(
    parameter int unsigned HOLD_CYC = prs_pkg::EXT_HOLD_CYC
) (
    input  wire logic          CLK_SYS,
    input  wire logic          RESET_N,
    input  wire logic          POWER_ON_SENSE_IN,
    input  wire logic          SUPPLY_OK_WARN_IN,
    input  wire prs_pkg::prs_ctrl_t CTRL,
    output logic               EXT_RESET_N_OUT,
    output prs_pkg::prs_stat_t STAT
);
    import prs_pkg::*;

    typedef struct packed {
        prs_state_t       state;
        logic [CNT_W-1:0] cnt;
        logic             ext_n;
        prs_stat_t        stat;
    } prs_seq_t;

    prs_seq_t seq_reg;
    prs_seq_t seq_next;
    logic     sense_sync;
    logic     good_sync;
    logic     good_q;

    // Sense is not filtered: its low must act at once
    prs_filter #(.RISE_CYC(1), .FALL_CYC(1), .CW(FLT_W)) u_sense (
        .CLK_SYS  (CLK_SYS),
        .RESET_N  (RESET_N),
        .raw_in   (POWER_ON_SENSE_IN),
        .sync_out (sense_sync),
        .qual_out ()
    );

    // [RULE11] Qualify high 625ns
    // [RULE8] Glitch filter low
    prs_filter #(.RISE_CYC(GOOD_HIGH_CYC), .FALL_CYC(GOOD_LOW_CYC), .CW(FLT_W)) u_good (
        .CLK_SYS  (CLK_SYS),
        .RESET_N  (RESET_N),
        .raw_in   (SUPPLY_OK_WARN_IN),
        .sync_out (good_sync),
        .qual_out (good_q)
    );

    always_comb begin
        seq_next                  = seq_reg;
        seq_next.stat.good_active = good_q;
        seq_next.stat.park_req    = 1'b0;
        if (seq_reg.cnt != '0) begin
            seq_next.cnt = seq_reg.cnt - CNT_W'(1);
        end
        unique case (seq_reg.state)
            PRS_ST_PON_HELD: begin
                seq_next.ext_n = RESET_OUT_VAL;
                // [RULE2] Await software release
                if (sense_sync && good_q && CTRL.sw_release) begin
                    seq_next.state = PRS_ST_HOLD;
                    seq_next.cnt   = CNT_W'(HOLD_CYC);
                end
            end
            PRS_ST_RUN: begin
                // [RULE5] Software drives pin
                seq_next.ext_n           = ~CTRL.sw_force;
                seq_next.stat.ctrl_reset = 1'b0;
                // [RULE3] Start delayed assertion
                if (!good_q || CTRL.int_reset) begin
                    seq_next.state = PRS_ST_DELAY;
                    seq_next.cnt   = CNT_W'(EXT_DELAY_CYC - 1);
                end
            end
            PRS_ST_DELAY: begin
                // [RULE8] Park request
                seq_next.stat.park_req = (seq_reg.cnt == CNT_W'(EXT_DELAY_CYC - 1)) && !good_q;
                if (seq_reg.cnt == '0) begin
                    seq_next.ext_n           = RESET_OUT_VAL;
                    seq_next.stat.ctrl_reset = 1'b1;
                    seq_next.state           = good_q ? PRS_ST_HELD : PRS_ST_PARK;
                    seq_next.cnt             = CNT_W'(PARK_CYC);
                end
            end
            PRS_ST_PARK: begin
                // Park window after controller reset is asserted, before the held state
                if (seq_reg.cnt == '0) begin
                    seq_next.state = PRS_ST_HELD;
                end
            end
            PRS_ST_HELD: begin
                seq_next.ext_n = RESET_OUT_VAL;
                // [RULE9] Hold while supply low
                if (good_q && CTRL.sw_release) begin
                    seq_next.state = PRS_ST_HOLD;
                    seq_next.cnt   = CNT_W'(HOLD_CYC);
                end
            end
            PRS_ST_HOLD: begin
                // [RULE4] Minimum hold time
                seq_next.ext_n = RESET_OUT_VAL;
                if (!good_q) begin
                    seq_next.state = PRS_ST_HELD;
                end else if (seq_reg.cnt == '0) begin
                    // [RULE6] Good permits exit
                    seq_next.state           = PRS_ST_RUN;
                    seq_next.ext_n           = ~CTRL.sw_force;
                    seq_next.stat.ctrl_reset = 1'b0;
                end
            end
        endcase
        // [RULE1] Sense low overrides
        if (!sense_sync) begin
            seq_next.state           = PRS_ST_PON_HELD;
            seq_next.ext_n           = RESET_OUT_VAL;
            seq_next.stat.ctrl_reset = 1'b1;
            seq_next.cnt             = '0;
        end
        seq_next.stat.awaiting_release = (seq_next.state == PRS_ST_PON_HELD) || (seq_next.state == PRS_ST_HELD);
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RESET_N) begin
            seq_reg.state <= PRS_ST_PON_HELD;
            seq_reg.cnt   <= '0;
            seq_reg.ext_n <= RESET_OUT_VAL;
            seq_reg.stat  <= '{park_req: 1'b0, ctrl_reset: 1'b1, good_active: 1'b0, awaiting_release: 1'b1};
        end else begin
            seq_reg <= seq_next;
        end
    end

    assign EXT_RESET_N_OUT = seq_reg.ext_n;
    assign STAT            = seq_reg.stat;

    // Check-only counters: long spans are counted here, since repetitions get unrolled
    logic [CNT_W-1:0] chk_dly_cnt;
    logic [CNT_W-1:0] chk_hold_cnt;

    // [RULE3] Delay window observer
    always_ff @(posedge CLK_SYS) begin
        if (!RESET_N) begin
            chk_dly_cnt <= '0;
        end else if (!sense_sync) begin
            chk_dly_cnt <= '0;
        end else if (seq_reg.state == PRS_ST_RUN && CTRL.int_reset && !CTRL.sw_force) begin
            chk_dly_cnt <= CNT_W'(EXT_DELAY_CYC);
        end else if (chk_dly_cnt != '0) begin
            chk_dly_cnt <= chk_dly_cnt - CNT_W'(1);
        end
    end

    // [RULE4] Low time since release
    always_ff @(posedge CLK_SYS) begin
        if (!RESET_N) begin
            chk_hold_cnt <= '0;
        end else if (seq_reg.stat.awaiting_release || EXT_RESET_N_OUT) begin
            chk_hold_cnt <= '0;
        end else if (chk_hold_cnt != '1) begin
            chk_hold_cnt <= chk_hold_cnt + CNT_W'(1);
        end
    end

    property p_sense_low;
        @(posedge CLK_SYS) disable iff (!RESET_N)
        !sense_sync |=> !EXT_RESET_N_OUT;
    endproperty
    a_sense_low: assert property (p_sense_low) else $error("Reset pin high while sense low"); // [RULE1]

    property p_no_self_release;
        @(posedge CLK_SYS) disable iff (!RESET_N)
        (seq_reg.state == PRS_ST_PON_HELD && !CTRL.sw_release) |=> !EXT_RESET_N_OUT;
    endproperty
    a_no_self_release: assert property (p_no_self_release) else $error("Reset released without software"); // [RULE2]

    property p_delay;
        @(posedge CLK_SYS) disable iff (!RESET_N)
        (chk_dly_cnt != '0) |-> EXT_RESET_N_OUT;
    endproperty
    a_delay: assert property (p_delay) else $error("Reset pin asserted before delay"); // [RULE3]

    property p_delay_end;
        @(posedge CLK_SYS) disable iff (!RESET_N)
        (chk_dly_cnt == CNT_W'(1)) |-> ##2 !EXT_RESET_N_OUT;
    endproperty
    a_delay_end: assert property (p_delay_end) else $error("Reset pin not asserted after delay"); // [RULE3]

    property p_hold;
        @(posedge CLK_SYS) disable iff (!RESET_N)
        $rose(EXT_RESET_N_OUT) |-> $past(seq_reg.state) == PRS_ST_HOLD || $past(seq_reg.state) == PRS_ST_RUN;
    endproperty
    a_hold: assert property (p_hold) else $error("Reset released without hold"); // [RULE4]

    property p_hold_len;
        @(posedge CLK_SYS) disable iff (!RESET_N)
        ($rose(EXT_RESET_N_OUT) && $past(seq_reg.state) == PRS_ST_HOLD) |-> chk_hold_cnt >= CNT_W'(HOLD_CYC);
    endproperty
    a_hold_len: assert property (p_hold_len) else $error("Reset hold shorter than minimum"); // [RULE4]

    property p_force;
        @(posedge CLK_SYS) disable iff (!RESET_N)
        (seq_reg.state == PRS_ST_RUN && CTRL.sw_force) |=> !EXT_RESET_N_OUT;
    endproperty
    a_force: assert property (p_force) else $error("Software force ignored"); // [RULE5]

    property p_good_exit;
        @(posedge CLK_SYS) disable iff (!RESET_N)
        (seq_reg.state == PRS_ST_HOLD && !good_q) |=> seq_reg.state != PRS_ST_RUN;
    endproperty
    a_good_exit: assert property (p_good_exit) else $error("Left reset without supply ok"); // [RULE6]

    property p_held;
        @(posedge CLK_SYS) disable iff (!RESET_N)
        (seq_reg.state == PRS_ST_HELD && !good_q) |=> seq_reg.state == PRS_ST_HELD || seq_reg.state == PRS_ST_PON_HELD;
    endproperty
    a_held: assert property (p_held) else $error("Left held state while supply low"); // [RULE9]

    property p_good_rise;
        @(posedge CLK_SYS) disable iff (!RESET_N)
        $rose(good_q) |-> $past(good_sync, 12);
    endproperty
    a_good_rise: assert property (p_good_rise) else $error("Supply ok qualified too soon"); // [RULE11]

endmodule

//--- shared/prs_pkg.sv
/*
 * Package for the power and reset sequencer: timing constants, state
 * enumeration and the user-side carrier structs.
 * Assumes a single system clock of CLK_SYS_MHZ and no software bus.
 */
package prs_pkg;

    localparam int unsigned CLK_SYS_MHZ      = 20;
    localparam int unsigned CLK_PERIOD_NS    = 1000 / CLK_SYS_MHZ;

    // Times as printed
    localparam int unsigned EXT_DELAY_US     = 5;
    localparam int unsigned EXT_HOLD_MS      = 2;
    localparam int unsigned GOOD_LOW_MIN_US  = 4;
    localparam int unsigned GOOD_HIGH_MIN_NS = 625;

    // Cycle counts; least times round up, the approximate delay rounds down
    localparam int unsigned EXT_DELAY_CYC    = (EXT_DELAY_US * 1000) / CLK_PERIOD_NS;
    localparam int unsigned EXT_HOLD_CYC     = (EXT_HOLD_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned GOOD_LOW_CYC     = (GOOD_LOW_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned GOOD_HIGH_CYC    = (GOOD_HIGH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam int unsigned PARK_CYC         = 16;
    localparam int unsigned CNT_W            = 16;
    localparam int unsigned FLT_W            = 8;

    localparam logic        RESET_OUT_VAL    = 1'b0;

    typedef enum logic [2:0] {
        PRS_ST_PON_HELD,
        PRS_ST_RUN,
        PRS_ST_DELAY,
        PRS_ST_PARK,
        PRS_ST_HELD,
        PRS_ST_HOLD
    } prs_state_t;

    // Software side controls
    typedef struct packed {
        logic sw_release;
        logic sw_force;
        logic int_reset;
    } prs_ctrl_t;

    // Status returned to the controller
    typedef struct packed {
        logic park_req;
        logic ctrl_reset;
        logic good_active;
        logic awaiting_release;
    } prs_stat_t;

endpackage

//--- src/prs_filter.sv
/*
 * Synchroniser and minimum-duration qualifier for one supervision input.
 * Assumes the input may be asynchronous to CLK_SYS.
 */
`timescale 1ns/1ns
module prs_filter #(
    parameter int unsigned RISE_CYC = 1,
    parameter int unsigned FALL_CYC = 1,
    parameter int unsigned CW       = 8
) (
    input  wire logic CLK_SYS,
    input  wire logic RESET_N,
    input  wire logic raw_in,
    output logic      sync_out,
    output logic      qual_out
);
    import prs_pkg::*;

    typedef struct packed {
        logic          s1;
        logic          s2;
        logic          q;
        logic [CW-1:0] cnt;
    } prs_flt_t;

    prs_flt_t st_reg;
    prs_flt_t st_next;

    // [RULE13] Sync then filter
    always_comb begin
        st_next    = st_reg;
        st_next.s1 = raw_in;
        st_next.s2 = st_reg.s1;
        if (st_reg.s2 == st_reg.q) begin
            st_next.cnt = '0;
        end else if (st_reg.cnt >= CW'(((st_reg.q ? FALL_CYC : RISE_CYC)) - 1)) begin
            st_next.q   = st_reg.s2;
            st_next.cnt = '0;
        end else begin
            st_next.cnt = st_reg.cnt + CW'(1);
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RESET_N) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign sync_out = st_reg.s2;
    assign qual_out = st_reg.q;

endmodule

//--- dv/prs_monitor_model.sv
/*
 * Behavioural supply monitor driving power-on sense and supply-ok warning.
 * Assumes the bench raises supply_up for good supplies and warn to force a fault.
 */
`timescale 1ns/1ns
module prs_monitor_model #(
    parameter int unsigned WARN_CYC = 10000
) (
    input  wire logic clk,
    input  wire logic supply_up,
    input  wire logic warn,
    output logic      sense_out,
    output logic      good_out
);
    int unsigned cnt;

    initial begin
        sense_out = 1'b0;
        good_out  = 1'b0;
        cnt       = 0;
    end

    always @(posedge clk) begin
        good_out <= supply_up && !warn;
        // Sense falls after the warning window
        if (supply_up) begin
            cnt       <= 0;
            sense_out <= 1'b1;
        end else if (cnt < WARN_CYC) begin
            cnt <= cnt + 1;
        end else begin
            sense_out <= 1'b0;
        end
    end
endmodule

//--- dv/tb_prs_sequencer.sv
/*
 * Self-checking bench for the power and reset sequencer.
 * Assumes a shortened hold count; the monitor model drives both inputs.
 */
`timescale 1ns/1ns
module tb_prs_sequencer;
    import prs_pkg::*;
    localparam int unsigned HOLD = 50;
    localparam int unsigned WARN = 10000;
    logic      clk_sys;
    logic      reset_n;
    logic      supply_up;
    logic      warn;
    logic      sense;
    logic      good;
    logic      ext_n;
    prs_ctrl_t ctrl;
    prs_stat_t stat;
    int        num_errors = 0;
    int        num_checks = 0;
    int        cycles     = 0;
    int        parks      = 0;
    int        n;

    prs_sequencer #(.HOLD_CYC(HOLD)) prs_sequencer_i (.CLK_SYS(clk_sys), .RESET_N(reset_n),
        .POWER_ON_SENSE_IN(sense), .SUPPLY_OK_WARN_IN(good), .CTRL(ctrl), .EXT_RESET_N_OUT(ext_n), .STAT(stat));
    prs_monitor_model #(.WARN_CYC(WARN)) prs_monitor_model_i (.clk(clk_sys), .supply_up(supply_up),
        .warn(warn), .sense_out(sense), .good_out(good));

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        cycles++;
        if (stat.park_req === 1'b1) parks++;
        if (cycles == 60000) begin
            num_errors++;
            report_and_stop();
        end
    end

    task automatic cyc(input int k);
        repeat (k) @(posedge clk_sys);
        #5;
    endtask

    task automatic chk(input logic got, input logic exp, input string msg);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask

    task automatic release_hold();
        ctrl.sw_release = 1'b1;
        cyc(HOLD - 1);
        chk(ext_n, 1'b0, "pin rose before hold");
        cyc(6);
        chk(ext_n, 1'b1, "pin not released");
        chk(stat.ctrl_reset, 1'b0, "controller still reset");
        ctrl.sw_release = 1'b0;
        cyc(2);
    endtask

    task automatic t_power_up();
        supply_up = 1'b1;
        cyc(40);
        chk(ext_n, 1'b0, "pin released without software");
        chk(stat.good_active, 1'b1, "supply ok not qualified");
        release_hold();
    endtask

    task automatic t_glitch();
        n = parks;
        warn = 1'b1;
        cyc(GOOD_LOW_CYC - 1);
        warn = 1'b0;
        cyc(200);
        chk(ext_n, 1'b1, "glitch reset the pin");
        chk(logic'(parks == n), 1'b1, "glitch requested park");
    endtask

    task automatic t_fault();
        int k;
        n = parks;
        warn = 1'b1;
        k = 0;
        while (k < 300 && ext_n === 1'b1) begin
            cyc(1);
            k++;
        end
        chk(logic'(k >= GOOD_LOW_CYC + EXT_DELAY_CYC && k <= GOOD_LOW_CYC + EXT_DELAY_CYC + 8), 1'b1, "fault delay wrong");
        chk(logic'(parks == n + 1), 1'b1, "no single park request");
        cyc(200);
        chk(ext_n, 1'b0, "pin left reset while supply low");
        chk(stat.ctrl_reset, 1'b1, "controller left reset");
        warn = 1'b0;
        cyc(40);
        release_hold();
    endtask

    task automatic t_internal();
        ctrl.int_reset = 1'b1;
        cyc(1);
        ctrl.int_reset = 1'b0;
        cyc(EXT_DELAY_CYC - 6);
        chk(ext_n, 1'b1, "internal reset too early");
        cyc(10);
        chk(ext_n, 1'b0, "internal reset missing");
        release_hold();
    endtask

    task automatic t_force();
        ctrl.sw_force = 1'b1;
        cyc(4);
        chk(ext_n, 1'b0, "force did not drive pin");
        ctrl.sw_force = 1'b0;
        cyc(HOLD + 6);
        chk(ext_n, 1'b1, "pin stuck after force");
    endtask

    task automatic t_power_loss();
        supply_up = 1'b0;
        cyc(WARN + 20);
        chk(ext_n, 1'b0, "pin high with sense low");
        supply_up = 1'b1;
        cyc(40);
        chk(ext_n, 1'b0, "pin released without software");
        release_hold();
    endtask

    task automatic report_and_stop();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        reset_n   = 1'b0;
        supply_up = 1'b0;
        warn      = 1'b0;
        ctrl      = '0;
        cyc(5);
        chk(ext_n, 1'b0, "pin high in reset");
        chk(stat.awaiting_release, 1'b1, "not awaiting release");
        reset_n = 1'b1;
        t_power_up();
        t_glitch();
        t_fault();
        t_internal();
        t_force();
        t_power_loss();
        report_and_stop();
    end
endmodule
